// file: shared/acrm_map.svh
// register offsets, field positions, reset values and sizes of the converter setup bank
`ifndef ACRM_MAP_SVH
`define ACRM_MAP_SVH
`define ACRM_ADDR_SETUP   13'h0000
`define ACRM_ADDR_ID      13'h0001
`define ACRM_ADDR_GRADE   13'h0002
`define ACRM_ADDR_INDEX   13'h0005
`define ACRM_ADDR_XFER    13'h00FF
`define ACRM_ADDR_FN_LO   13'h0008
`define ACRM_ADDR_FN_HI   13'h0020
`define ACRM_ADDR_FN_SYNC 13'h003A
`define ACRM_ADDR_POWER   13'h0008
`define ACRM_IDX_GCLK     5'h01
`define ACRM_IDX_OUTFMT   5'h0C
`define ACRM_IDX_SYNC     5'h19
`define ACRM_FN_COUNT     26
`define ACRM_RST_SETUP    8'h18
`define ACRM_RST_INDEX    2'h3
`define ACRM_RST_GCLK     8'h01
`define ACRM_RST_OUTFMT   8'h05
`define ACRM_RST_FN       8'h00
`define ACRM_SETUP_LSB_H  6
`define ACRM_SETUP_LSB_L  1
`define ACRM_SETUP_SRST_H 5
`define ACRM_SETUP_SRST_L 2
`define ACRM_GRADE_POS    4
`define ACRM_XFER_BIT     0
`define ACRM_INSTR_BITS   16
`define ACRM_BYTE_LAST    4'h7
`define ACRM_INSTR_LAST   4'hF
`endif

// file: shared/acrm_pkg.sv
// types shared by the converter setup bank
`default_nettype none
package acrm_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_INSTR = 4'b0010,
        ST_DATA  = 4'b0100,
        ST_DONE  = 4'b1000
    } acrm_state_e;

    typedef struct packed {
        logic        rd;
        logic [1:0]  wlen;
        logic [12:0] addr;
    } acrm_instr_s;

    typedef struct packed {
        logic       en;
        logic [4:0] idx;
        logic [7:0] data;
    } acrm_wr_s;
endpackage
`default_nettype wire

// file: rtl/acrm_chan_bank.sv
// one channel copy of the shadowed function registers: holding and active sets
`timescale 1ns/1ps
`default_nettype none
`include "acrm_map.svh"
module acrm_chan_bank
    import acrm_pkg::*;
#(
    parameter int NREG = `ACRM_FN_COUNT
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    input  wire logic              soft_rst_i,
    input  wire logic              xfer_i,
    input  wire acrm_wr_s          wr_i,
    input  wire logic [4:0]        rd_idx_i,
    output logic      [7:0]        rd_data_o,
    output logic      [NREG*8-1:0] active_o
);
    logic [7:0]        hold   [NREG];
    logic [7:0]        active [NREG];
    logic [NREG*8-1:0] hold_flat;

    function automatic logic [7:0] dflt(input int i);
        if (i == int'(`ACRM_IDX_OUTFMT)) begin
            return `ACRM_RST_OUTFMT;
        end else if (i == int'(`ACRM_IDX_GCLK)) begin
            return `ACRM_RST_GCLK;
        end
        return `ACRM_RST_FN;
    endfunction

    // holding copy takes host writes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NREG; i++) hold[i] <= dflt(i);
        end else if (ce_i) begin
            if (soft_rst_i) begin
                for (int i = 0; i < NREG; i++) hold[i] <= dflt(i);
            end else if (wr_i.en && int'(wr_i.idx) < NREG) begin
                hold[wr_i.idx] <= wr_i.data;
            end
        end
    end

    // active copy changes only on transfer or soft reset, all entries at once
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NREG; i++) active[i] <= dflt(i);
        end else if (ce_i) begin
            if (soft_rst_i) begin
                for (int i = 0; i < NREG; i++) active[i] <= dflt(i);
            end else if (xfer_i) begin
                for (int i = 0; i < NREG; i++) active[i] <= hold[i];
            end
        end
    end

    for (genvar g = 0; g < NREG; g++) begin : g_flat
        assign active_o[g*8 +: 8]  = active[g];
        assign hold_flat[g*8 +: 8] = hold[g];
    end

    assign rd_data_o = (int'(rd_idx_i) < NREG) ? hold[rd_idx_i] : 8'h00;

    AST_SHADOW_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !xfer_i && !soft_rst_i |=> $stable(active_o))
        else $error("active set moved without transfer");
    AST_XFER_COPY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && xfer_i && !soft_rst_i |=> active_o == $past(hold_flat))
        else $error("transfer did not copy holding set");
endmodule
`default_nettype wire

// file: rtl/acrm_register_map.sv
// serial-port setup register bank of the dual converter
`timescale 1ns/1ps
`default_nettype none
`include "acrm_map.svh"
module acrm_register_map
    import acrm_pkg::*;
#(
    parameter logic [7:0] PART_ID     = 8'h5A, // arbitrary value
    parameter logic [1:0] SPEED_GRADE = 2'h0
) (
    input  wire logic                         MCLK_I,
    input  wire logic                         ARST_N_I,
    input  wire logic                         CE_I,
    input  wire logic                         SCLK_I,
    input  wire logic                         CSB_N_I,
    input  wire logic                         SDIO_I,
    output logic                              SDIO_O,
    output logic                              SDIO_OE_O,
    output logic [`ACRM_FN_COUNT*8-1:0]       ACTIVE_A_O,
    output logic [`ACRM_FN_COUNT*8-1:0]       ACTIVE_B_O
);
    acrm_state_e state;
    acrm_instr_s instr;
    logic        sclk_q;
    logic [3:0]  bit_cnt;
    logic [14:0] shreg;
    logic [12:0] addr;
    logic [1:0]  bytes_left;
    logic [7:0]  tx;
    logic        lsb_first;
    logic [1:0]  chan_sel;
    logic        xfer;
    logic        soft_rst;
    acrm_wr_s    wr;
    logic [1:0]  wr_ch;
    logic        rise, fall, commit, instr_end, byte_end;
    logic [15:0] in_word;
    logic [7:0]  in_byte;
    acrm_instr_s dec;
    logic [12:0] next_addr, look_addr;
    logic [7:0]  look_byte, rd_a, rd_b;
    logic [15:0] in_rev;
    logic [7:0]                  rd_ch  [2];
    logic [`ACRM_FN_COUNT*8-1:0] act_ch [2];

    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int i = 0; i < 16; i++) rev16[i] = v[15-i];
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
    endfunction

    function automatic logic is_fn(input logic [12:0] a);
        return (a >= `ACRM_ADDR_FN_LO && a <= `ACRM_ADDR_FN_HI) || a == `ACRM_ADDR_FN_SYNC;
    endfunction

    function automatic logic [4:0] fn_idx(input logic [12:0] a);
        logic [12:0] d;
        d = a - `ACRM_ADDR_FN_LO;
        return (a == `ACRM_ADDR_FN_SYNC) ? `ACRM_IDX_SYNC : d[4:0];
    endfunction

    function automatic logic is_local(input logic [12:0] a);
        return a == `ACRM_ADDR_POWER;
    endfunction

    assign rise      = CE_I && !CSB_N_I && SCLK_I && !sclk_q;
    assign fall      = CE_I && !CSB_N_I && !SCLK_I && sclk_q;
    assign in_rev    = rev16({shreg, SDIO_I});
    assign in_word   = lsb_first ? in_rev : {shreg, SDIO_I};
    assign in_byte   = lsb_first ? in_rev[15:8] : {shreg[6:0], SDIO_I};
    assign dec       = acrm_instr_s'(in_word);
    assign instr_end = rise && (state == ST_IDLE || state == ST_INSTR)
                       && bit_cnt == `ACRM_INSTR_LAST;
    assign byte_end  = rise && state == ST_DATA && bit_cnt == `ACRM_BYTE_LAST;
    assign commit    = byte_end && !instr.rd;
    assign next_addr = lsb_first ? addr + 13'h0001 : addr - 13'h0001;
    assign look_addr = (state == ST_DATA) ? next_addr : dec.addr;

    // read decode: local reads with both bits set come from channel A
    always_comb begin
        look_byte = 8'h00;
        if (look_addr == `ACRM_ADDR_SETUP) begin
            look_byte = `ACRM_RST_SETUP;
            look_byte[`ACRM_SETUP_LSB_H] = lsb_first;
            look_byte[`ACRM_SETUP_LSB_L] = lsb_first;
        end else if (look_addr == `ACRM_ADDR_ID) begin
            look_byte = PART_ID;
        end else if (look_addr == `ACRM_ADDR_GRADE) begin
            look_byte[`ACRM_GRADE_POS +: 2] = SPEED_GRADE;
        end else if (look_addr == `ACRM_ADDR_INDEX) begin
            look_byte = {6'h00, chan_sel};
        end else if (is_fn(look_addr)) begin
            look_byte = (is_local(look_addr) && !chan_sel[0] && chan_sel[1]) ? rd_b : rd_a;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sclk_q <= 1'b0;
        end else if (CE_I) begin
            sclk_q <= SCLK_I;
        end
    end

    // frame sequencing: instruction, then bytes until length or chip select ends it
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state      <= ST_IDLE;
            bit_cnt    <= 4'h0;
            shreg      <= 15'h0000;
            instr      <= '0;
            addr       <= 13'h0000;
            bytes_left <= 2'h0;
        end else if (CE_I) begin
            if (CSB_N_I) begin
                state   <= ST_IDLE;
                bit_cnt <= 4'h0;
            end else if (rise) begin
                shreg   <= {shreg[13:0], SDIO_I};
                bit_cnt <= bit_cnt + 4'h1;
                case (state)
                    ST_IDLE, ST_INSTR: begin
                        state <= instr_end ? ST_DATA : ST_INSTR;
                        if (instr_end) begin
                            instr      <= dec;
                            addr       <= dec.addr;
                            bytes_left <= dec.wlen;
                            bit_cnt    <= 4'h0;
                        end
                    end
                    ST_DATA: begin
                        if (byte_end) begin
                            bit_cnt <= 4'h0;
                            addr    <= next_addr;
                            if (instr.wlen != 2'h3) begin
                                bytes_left <= bytes_left - 2'h1;
                                if (bytes_left == 2'h0) begin
                                    state <= ST_DONE;
                                end
                            end
                        end
                    end
                    ST_DONE: state <= ST_DONE;
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // read data leaves on falling edges, first bit after the instruction
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tx        <= 8'h00;
            SDIO_O    <= 1'b0;
            SDIO_OE_O <= 1'b0;
        end else if (CE_I) begin
            if (CSB_N_I) begin
                SDIO_OE_O <= 1'b0;
            end else if ((instr_end && dec.rd) || (byte_end && instr.rd)) begin
                tx <= lsb_first ? rev8(look_byte) : look_byte;
            end else if (fall) begin
                SDIO_OE_O <= state == ST_DATA && instr.rd;
                if (state == ST_DATA && instr.rd) begin
                    SDIO_O <= tx[7];
                    tx     <= {tx[6:0], 1'b0};
                end
            end
        end
    end

    // write commit into setup, index, transfer and function registers
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            lsb_first <= 1'b0;
            chan_sel  <= `ACRM_RST_INDEX;
            xfer      <= 1'b0;
            soft_rst  <= 1'b0;
            wr        <= '0;
            wr_ch     <= 2'h0;
        end else if (CE_I) begin
            xfer     <= commit && addr == `ACRM_ADDR_XFER && in_byte[`ACRM_XFER_BIT];
            soft_rst <= commit && addr == `ACRM_ADDR_SETUP
                        && (in_byte[`ACRM_SETUP_SRST_H] || in_byte[`ACRM_SETUP_SRST_L]);
            wr.en    <= commit && is_fn(addr);
            wr.idx   <= fn_idx(addr);
            wr.data  <= in_byte;
            wr_ch    <= is_local(addr) ? chan_sel : 2'h3;
            if (soft_rst) begin
                lsb_first <= 1'b0;
                chan_sel  <= `ACRM_RST_INDEX;
            end else if (commit && addr == `ACRM_ADDR_SETUP) begin
                lsb_first <= in_byte[`ACRM_SETUP_LSB_H] || in_byte[`ACRM_SETUP_LSB_L];
            end else if (commit && addr == `ACRM_ADDR_INDEX) begin
                chan_sel <= in_byte[1:0];
            end
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_chan
        acrm_wr_s ch_wr;
        assign ch_wr = '{en: wr.en && wr_ch[c], idx: wr.idx, data: wr.data};
        acrm_chan_bank #(
            .NREG (`ACRM_FN_COUNT)
        ) u_bank (
            .clk_i      (MCLK_I),
            .rst_n_i    (ARST_N_I),
            .ce_i       (CE_I),
            .soft_rst_i (soft_rst),
            .xfer_i     (xfer),
            .wr_i       (ch_wr),
            .rd_idx_i   (fn_idx(look_addr)),
            .rd_data_o  (rd_ch[c]),
            .active_o   (act_ch[c])
        );
    end

    assign rd_a       = rd_ch[0];
    assign rd_b       = rd_ch[1];
    assign ACTIVE_A_O = act_ch[0];
    assign ACTIVE_B_O = act_ch[1];

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);

    AST_XFER_CAUSE: assert property (xfer |-> $past(commit) && $past(addr) == `ACRM_ADDR_XFER)
        else $error("transfer without write to transfer register");
    AST_XFER_CLEAR: assert property (xfer && CE_I |=> !xfer)
        else $error("transfer bit did not clear");
    AST_BOTH_WRITE: assert property (commit && is_local(addr) && chan_sel == 2'h3
        |=> wr.en && wr_ch == 2'h3)
        else $error("local write missed a channel");
    AST_LOCAL_STEER: assert property (commit && is_local(addr) |=> wr_ch == $past(chan_sel))
        else $error("local write steered wrongly");
    AST_GLOBAL_WRITE: assert property (commit && is_fn(addr) && !is_local(addr)
        |=> wr.en && wr_ch == 2'h3)
        else $error("global write not shared");
    AST_READ_A: assert property (is_local(look_addr) && chan_sel == 2'h3
        |-> look_byte == rd_a)
        else $error("both-channel read not from A");
    AST_UNSUP: assert property (commit && !is_fn(addr) && addr != `ACRM_ADDR_SETUP
        && addr != `ACRM_ADDR_INDEX && addr != `ACRM_ADDR_XFER
        |=> !wr.en && !xfer && !soft_rst)
        else $error("unsupported write took effect");
    AST_SETUP_MIRROR: assert property (look_addr == `ACRM_ADDR_SETUP
        |-> look_byte[4:3] == 2'h3 && look_byte[6] == look_byte[1])
        else $error("setup byte not mirrored");
    AST_GRADE: assert property (look_addr == `ACRM_ADDR_GRADE
        |-> look_byte == {2'h0, SPEED_GRADE, 4'h0})
        else $error("grade byte wrong");
    AST_SOFT_DFLT: assert property (soft_rst && CE_I |=> chan_sel == `ACRM_RST_INDEX
        && !lsb_first && ACTIVE_A_O[8*`ACRM_IDX_OUTFMT +: 8] == `ACRM_RST_OUTFMT)
        else $error("soft reset left a non-default");
    AST_INSTR_LEN: assert property ($rose(state == ST_DATA) |-> $past(bit_cnt) == `ACRM_INSTR_LAST)
        else $error("instruction not 16 bits");

    CV_READ: cover property (SDIO_OE_O && fall);
    CV_XFER: cover property (xfer);
    CV_SOFT: cover property (soft_rst);
    CV_BOTH: cover property (wr.en && wr_ch == 2'h3);
endmodule
`default_nettype wire

// file: bench/acrm_host_model.sv
// serial-port host model that frames instruction and data bits on the setup port
`timescale 1ns/1ps
`default_nettype none
module acrm_host_model
    import acrm_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic sdio_oe_i,
    input  wire logic sdio_dev_i,
    output logic      sclk_o,
    output logic      csb_n_o,
    output logic      sdio_o
);
    logic lsb_first = 1'b0;
    logic host_drive = 1'b0;
    logic host_bit = 1'b0;
    logic noise = 1'b0;

    // released line shows a changing level, never the last driven bit
    always @(negedge clk_i) noise <= ~noise;
    always_comb sdio_o = sdio_oe_i ? sdio_dev_i : (host_drive ? host_bit : noise);

    initial begin
        sclk_o = 1'b0;
        csb_n_o = 1'b1;
    end

    // one frame: 16 instruction bits, then one data byte; sclk idles low
    task automatic frame(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
                         output logic [7:0] rdat);
        logic [15:0] ins;
        int          k;
        ins = {rd, 2'b00, addr};
        rdat = 8'h00;
        csb_n_o = 1'b0;
        for (int i = 0; i < 24; i++) begin
            k = (i < 16) ? (lsb_first ? i : 15 - i) : (lsb_first ? i - 16 : 23 - i);
            sclk_o = 1'b0;
            host_drive = !(rd && i >= 16);
            host_bit = (i < 16) ? ins[k] : wd[k];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            if (i >= 16) rdat[k] = sdio_o;
            repeat (4) @(negedge clk_i);
        end
        sclk_o = 1'b0;
        repeat (4) @(negedge clk_i);
        csb_n_o = 1'b1;
        host_drive = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench of the converter setup register bank
`timescale 1ns/1ps
`default_nettype none
`include "acrm_map.svh"
module testbench;
    import acrm_pkg::*;
    localparam logic [7:0] PID = 8'h3C; // arbitrary value
    localparam logic [1:0] GRADE = 2'h1;
    localparam logic [7:0] GRADE_BYTE = {2'h0, GRADE, 4'h0};
    logic                         mclk = 1'b0;
    logic                         arst_n = 1'b0;
    logic                         ce = 1'b1;
    logic                         sclk;
    logic                         csb_n;
    logic                         sdio_wire;
    logic                         sdio_dev;
    logic                         sdio_oe;
    logic [`ACRM_FN_COUNT*8-1:0]  act_a;
    logic [`ACRM_FN_COUNT*8-1:0]  act_b;
    logic [7:0]                   d;
    int                           miscompares = 0;
    int                           samples_checked = 0;
    logic [12:0] row_addr [9] = '{13'h0000, 13'h0001, 13'h0002, 13'h0005, 13'h0009,
                                  13'h0014, 13'h003A, 13'h00FF, 13'h0003};
    logic [7:0]  row_exp [9] = '{8'h18, PID, GRADE_BYTE, 8'h03, 8'h01,
                                 8'h05, 8'h00, 8'h00, 8'h00};

    always #5 mclk = ~mclk;

    acrm_register_map #(.PART_ID(PID), .SPEED_GRADE(GRADE)) acrm_register_map_i (
        .MCLK_I(mclk), .ARST_N_I(arst_n), .CE_I(ce), .SCLK_I(sclk), .CSB_N_I(csb_n),
        .SDIO_I(sdio_wire), .SDIO_O(sdio_dev), .SDIO_OE_O(sdio_oe),
        .ACTIVE_A_O(act_a), .ACTIVE_B_O(act_b));

    acrm_host_model acrm_host_model_i (
        .clk_i(mclk), .sdio_oe_i(sdio_oe), .sdio_dev_i(sdio_dev),
        .sclk_o(sclk), .csb_n_o(csb_n), .sdio_o(sdio_wire));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [12:0] a, output logic [7:0] v);
        acrm_host_model_i.frame(1'b1, a, 8'h00, v);
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        logic [7:0] dummy;
        acrm_host_model_i.frame(1'b0, a, v, dummy);
    endtask

    task automatic end_sim;
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #400_000;
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (8) @(negedge mclk);
        arst_n = 1'b1;
        repeat (2) @(negedge mclk);
        for (int i = 0; i < 9; i++) begin
            rd(row_addr[i], d);
            check("reset read", d, row_exp[i]);
        end
        check("oe idle", {7'h00, sdio_oe}, 8'h00);
        check("active fmt", act_a[96 +: 8], 8'h05);
        wr(13'h0014, 8'h01);
        check("held fmt", act_a[96 +: 8], 8'h05);
        rd(13'h0014, d);
        check("holding fmt", d, 8'h01);
        wr(`ACRM_ADDR_XFER, 8'h01);
        check("fmt a", act_a[96 +: 8], 8'h01);
        check("fmt b", act_b[96 +: 8], 8'h01);
        rd(`ACRM_ADDR_XFER, d);
        check("xfer clear", d, 8'h00);
        wr(`ACRM_ADDR_INDEX, 8'h01);
        wr(`ACRM_ADDR_POWER, 8'h02);
        wr(`ACRM_ADDR_INDEX, 8'h02);
        wr(`ACRM_ADDR_POWER, 8'h03);
        rd(`ACRM_ADDR_POWER, d);
        check("local b", d, 8'h03);
        wr(`ACRM_ADDR_INDEX, 8'h01);
        rd(`ACRM_ADDR_POWER, d);
        check("local a", d, 8'h02);
        check("power held", act_a[0 +: 8], 8'h00);
        wr(`ACRM_ADDR_XFER, 8'h01);
        check("power a", act_a[0 +: 8], 8'h02);
        check("power b", act_b[0 +: 8], 8'h03);
        wr(`ACRM_ADDR_INDEX, 8'h03);
        wr(`ACRM_ADDR_POWER, 8'h01);
        wr(`ACRM_ADDR_XFER, 8'h01);
        check("both a", act_a[0 +: 8], 8'h01);
        check("both b", act_b[0 +: 8], 8'h01);
        wr(`ACRM_ADDR_INDEX, 8'h02);
        wr(`ACRM_ADDR_POWER, 8'h03);
        wr(`ACRM_ADDR_INDEX, 8'h03);
        rd(`ACRM_ADDR_POWER, d);
        check("both read", d, 8'h01);
        wr(`ACRM_ADDR_INDEX, 8'h01);
        wr(13'h0014, 8'h00);
        wr(`ACRM_ADDR_XFER, 8'h01);
        check("global b", act_b[96 +: 8], 8'h00);
        ce = 1'b0;
        wr(13'h0014, 8'h77);
        ce = 1'b1;
        rd(13'h0014, d);
        check("ce frozen", d, 8'h00);
        wr(13'h0003, 8'hAA);
        rd(13'h0003, d);
        check("unsupported", d, 8'h00);
        wr(`ACRM_ADDR_ID, 8'h00);
        rd(`ACRM_ADDR_ID, d);
        check("id kept", d, PID);
        wr(`ACRM_ADDR_SETUP, 8'h5A);
        acrm_host_model_i.lsb_first = 1'b1;
        rd(`ACRM_ADDR_SETUP, d);
        check("lsb setup", d, 8'h5A);
        rd(`ACRM_ADDR_GRADE, d);
        check("lsb grade", d, GRADE_BYTE);
        wr(`ACRM_ADDR_SETUP, 8'h3C);
        acrm_host_model_i.lsb_first = 1'b0;
        rd(`ACRM_ADDR_SETUP, d);
        check("soft setup", d, 8'h18);
        rd(13'h0014, d);
        check("soft fmt", d, 8'h05);
        rd(`ACRM_ADDR_INDEX, d);
        check("soft index", d, 8'h03);
        check("soft act a", act_a[96 +: 8], 8'h05);
        check("soft act b", act_b[0 +: 8], 8'h00);
        wr(13'h0014, 8'h00);
        wr(13'h0009, 8'h00);
        wr(`ACRM_ADDR_XFER, 8'h01);
        arst_n = 1'b0;
        repeat (2) @(negedge mclk);
        check("hard rst fmt", act_a[96 +: 8], 8'h05);
        check("hard rst clk", act_b[8 +: 8], 8'h01);
        arst_n = 1'b1;
        repeat (2) @(negedge mclk);
        rd(13'h0014, d);
        check("hard rst hold", d, 8'h05);
        end_sim();
    end
endmodule
`default_nettype wire
